/* File: logic/fsc_params.svh */
// constants for the fieldbus switch configuration decoder
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
`define FSC_DIP_RATE 0
`define FSC_DIP_LEN 1
`define FSC_DIP_BASE 2
`define FSC_DIP_RSVD 3
`define FSC_BASE_LO 7'h40
`define FSC_BASE_HI 7'h50
`define FSC_LEN_LONG 6'h20
`define FSC_LEN_SHORT 6'h11
`define FSC_ROT_DISABLED 4'h0
`define FSC_SETTLE_CYC 16'h0010
`define FSC_ADR_CTRL 32'h0000_0000
`define FSC_ADR_STAT 32'h0000_0004
`define FSC_ADR_IRQ_STAT 32'h0000_0008
`define FSC_ADR_IRQ_MASK 32'h0000_000C
`define FSC_ADR_SWRAW 32'h0000_0010
`define FSC_IRQ_LOADED 0
`define FSC_IRQ_CFGERR 1
`define FSC_IRQ_CHANGED 2
`define FSC_IRQ_W 3
`define FSC_SEL_CTRL 0
`define FSC_SEL_STAT 1
`define FSC_SEL_IRQ_STAT 2
`define FSC_SEL_IRQ_MASK 3
`define FSC_SEL_SWRAW 4
`define FSC_SEL_W 5
`define FSC_STAT_RATE 0
`define FSC_STAT_LEN 4
`define FSC_STAT_ADDR 12
`define FSC_STAT_VALID 19
`define FSC_STAT_ERR 20
`define FSC_STAT_LOADED 21
`endif

/* File: logic/fsc_pkg.sv */
// types for the fieldbus switch configuration decoder
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_RATE_4M = 2'b00,
    FSC_RATE_10M = 2'b01
  } fsc_rate_e;

  typedef struct packed {
    fsc_rate_e rate;
    logic [5:0] frameLen;
    logic [6:0] stationAddr;
    logic addrValid;
    logic cfgError;
  } fsc_cfg_s;

  typedef enum logic [1:0] {
    FSC_ST_SETTLE = 2'b00,
    FSC_ST_SAMPLE = 2'b01,
    FSC_ST_RUN = 2'b11
  } fsc_state_e;
endpackage : fsc_pkg

/* File: logic/fsc_switch_sync.sv */
// two-flop synchroniser for the switch pins
`timescale 1ns/1ps
module fsc_switch_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pinIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule : fsc_switch_sync

/* File: logic/fsc_decoder.sv */
// switch decoder with classic wishbone register slave and interrupt
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_decoder #(
  parameter logic [15:0] SETTLE_CYC = `FSC_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] comm_dip_switch,
  input wire logic [3:0] address_rotary_switch,
  output fsc_pkg::fsc_cfg_s cfgOut,
  output logic cfgLoaded,
  output logic irq,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  import fsc_pkg::*;

  logic [7:0] swSync;
  logic [3:0] dipNow;
  logic [3:0] rotNow;

  // pins come from mechanical switches: two flops before any decode
  fsc_switch_sync #(.WIDTH(8)) uSync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinIn({comm_dip_switch, address_rotary_switch}),
    .syncOut(swSync)
  );
  assign dipNow = swSync[7:4];
  assign rotNow = swSync[3:0];

  // frame length: the legacy rate forces the short frame, whatever
  // the length switch says, so a legacy master is never overrun
  function automatic logic [5:0] frameLenFor(input logic rateOn,
                                             input logic longOn);
    logic [5:0] len;
    len = `FSC_LEN_SHORT;
    if (rateOn && longOn) begin
      len = `FSC_LEN_LONG;
    end
    return len;
  endfunction : frameLenFor

  // rotary 0 on the low base is the disabled address, not 40h
  function automatic logic addrValidFor(input logic baseHi,
                                        input logic [3:0] rot);
    return baseHi || (rot != `FSC_ROT_DISABLED);
  endfunction : addrValidFor

  function automatic fsc_cfg_s decodeSwitches(input logic [3:0] dip,
                                               input logic [3:0] rot);
    fsc_cfg_s c;
    logic [6:0] base;
    c = '0;
    // the reserved position never reaches the decode
    c.rate = dip[`FSC_DIP_RATE] ? FSC_RATE_10M : FSC_RATE_4M;
    c.frameLen = frameLenFor(dip[`FSC_DIP_RATE],
                             dip[`FSC_DIP_LEN]);
    base = dip[`FSC_DIP_BASE] ? `FSC_BASE_HI : `FSC_BASE_LO;
    c.stationAddr = base + {3'h0, rot};
    c.addrValid = addrValidFor(dip[`FSC_DIP_BASE], rot);
    c.cfgError = !c.addrValid;
    return c;
  endfunction : decodeSwitches

  // one-hot register select for the read mux and the write strobes
  function automatic logic [`FSC_SEL_W-1:0] regSelect(
      input logic [31:0] adr);
    logic [`FSC_SEL_W-1:0] oneHot;
    oneHot = '0;
    // full address compare: aliases would hide stray accesses
    unique case (adr)
      `FSC_ADR_CTRL: begin
        oneHot[`FSC_SEL_CTRL] = 1'b1;
      end
      `FSC_ADR_STAT: begin
        oneHot[`FSC_SEL_STAT] = 1'b1;
      end
      `FSC_ADR_IRQ_STAT: begin
        oneHot[`FSC_SEL_IRQ_STAT] = 1'b1;
      end
      `FSC_ADR_IRQ_MASK: begin
        oneHot[`FSC_SEL_IRQ_MASK] = 1'b1;
      end
      `FSC_ADR_SWRAW: begin
        oneHot[`FSC_SEL_SWRAW] = 1'b1;
      end
      // unmapped offsets select nothing and are answered with err
      default: begin
        oneHot = '0;
      end
    endcase
    return oneHot;
  endfunction : regSelect

  // status word; unused bits read as zero so fields can grow later
  function automatic logic [31:0] packStatus(input fsc_cfg_s c,
                                             input logic loaded);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FSC_STAT_RATE +: 2] = c.rate;
    w[`FSC_STAT_LEN +: 6] = c.frameLen;
    w[`FSC_STAT_ADDR +: 7] = c.stationAddr;
    w[`FSC_STAT_VALID] = c.addrValid;
    w[`FSC_STAT_ERR] = c.cfgError;
    w[`FSC_STAT_LOADED] = loaded;
    return w;
  endfunction : packStatus

  // configuration capture
  fsc_state_e state_r;
  fsc_state_e state_nxt;
  logic [15:0] settle_r;
  logic [15:0] settle_nxt;
  fsc_cfg_s cfg_r;
  fsc_cfg_s cfg_nxt;
  logic [7:0] swHeld_r;
  logic [7:0] swHeld_nxt;
  logic loadEvt;
  logic chgEvt;

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    cfg_nxt = cfg_r;
    swHeld_nxt = swHeld_r;
    loadEvt = 1'b0;
    chgEvt = 1'b0;
    unique case (state_r)
      // wait for synchroniser and switch contacts to settle
      FSC_ST_SETTLE: begin
        if (settle_r >= SETTLE_CYC - 16'h0001) begin
          state_nxt = FSC_ST_SAMPLE;
        end else begin
          settle_nxt = settle_r + 16'h0001;
        end
      end
      FSC_ST_SAMPLE: begin
        cfg_nxt = decodeSwitches(dipNow, rotNow);
        swHeld_nxt = swSync;
        loadEvt = 1'b1;
        state_nxt = FSC_ST_RUN;
      end
      FSC_ST_RUN: begin
        // live moves are reported but never applied
        chgEvt = (swSync != swHeld_r);
        swHeld_nxt = swSync;
      end
      default: begin
        state_nxt = FSC_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r <= FSC_ST_SETTLE;
      settle_r <= 16'h0000;
      cfg_r <= '0;
      swHeld_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      cfg_r <= cfg_nxt;
      swHeld_r <= swHeld_nxt;
    end
  end

  assign cfgOut = cfg_r;
  assign cfgLoaded = (state_r == FSC_ST_RUN);

  // interrupt state: sticky status, mask and the events that set it
  logic [`FSC_IRQ_W-1:0] irqStat_r;
  logic [`FSC_IRQ_W-1:0] irqStat_nxt;
  logic [`FSC_IRQ_W-1:0] irqMask_r;
  logic [`FSC_IRQ_W-1:0] irqMask_nxt;
  logic [`FSC_IRQ_W-1:0] evts;

  // wishbone slave: one wait state, the answer stands for one cycle
  // read data keeps its last value between accesses
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic ack_r;
  logic ack_nxt;
  logic err_r;
  logic err_nxt;
  logic req;
  logic [`FSC_SEL_W-1:0] hit;
  logic wrLow;
  logic wrIrqStat;
  logic wrIrqMask;

  // no request is taken while an answer stands, so one access
  // can never be acknowledged twice
  assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  assign hit = req ? regSelect(wb_adr_i) : '0;
  // only the low byte lane carries writable bits
  assign wrLow = req && wb_we_i && wb_sel_i[0];
  assign wrIrqStat = wrLow && hit[`FSC_SEL_IRQ_STAT];
  assign wrIrqMask = wrLow && hit[`FSC_SEL_IRQ_MASK];

  always_comb begin
    rdat_nxt = rdat_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (req) begin
      ack_nxt = |hit;
      err_nxt = !(|hit);
      rdat_nxt = 32'h0000_0000;
      unique case (1'b1)
        hit[`FSC_SEL_CTRL]: begin
          rdat_nxt = 32'h0000_0000;
        end
        hit[`FSC_SEL_STAT]: begin
          rdat_nxt = packStatus(cfg_r, cfgLoaded);
        end
        hit[`FSC_SEL_IRQ_STAT]: begin
          rdat_nxt = {{(32-`FSC_IRQ_W){1'b0}}, irqStat_r};
        end
        hit[`FSC_SEL_IRQ_MASK]: begin
          rdat_nxt = {{(32-`FSC_IRQ_W){1'b0}}, irqMask_r};
        end
        hit[`FSC_SEL_SWRAW]: begin
          // raw synced pins show a switch move that is still pending
          rdat_nxt = {24'h00_0000, swSync};
        end
        // unmapped: err, nothing read and nothing written
        default: begin
          rdat_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rdat_r <= rdat_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;

  // load and error fire in the sample cycle, from the value being stored
  always_comb begin
    evts = '0;
    evts[`FSC_IRQ_LOADED] = loadEvt;
    evts[`FSC_IRQ_CFGERR] = loadEvt && cfg_nxt.cfgError;
    evts[`FSC_IRQ_CHANGED] = chgEvt;
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    if (wrIrqStat) begin
      irqStat_nxt = irqStat_r & ~wb_dat_i[`FSC_IRQ_W-1:0];
    end
    if (wrIrqMask) begin
      irqMask_nxt = wb_dat_i[`FSC_IRQ_W-1:0];
    end
    // set wins over a same-cycle write-one clear, so no event is lost
    irqStat_nxt = irqStat_nxt | evts;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // level output: stays high until software clears or masks the cause
  assign irq = |(irqStat_r & irqMask_r);
endmodule : fsc_decoder

/* File: tb/fsc_switch_panel.sv */
// switch panel model driving the dip and rotary pins
`timescale 1ns/1ps
module fsc_switch_panel (
  input wire logic clk_sys,
  input wire logic [7:0] setting,
  output logic [3:0] dipPins,
  output logic [3:0] rotPins
);
  always_ff @(posedge clk_sys) begin
    {dipPins, rotPins} <= setting;
  end
endmodule : fsc_switch_panel

/* File: tb/fsc_decoder_chk.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module fsc_decoder_chk
  import fsc_pkg::*;
#(
  parameter logic [15:0] SETTLE_CYC = 16'h0010
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] comm_dip_switch,
  input wire logic [3:0] address_rotary_switch,
  input wire fsc_cfg_s cfgOut,
  input wire logic cfgLoaded,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o
);
  localparam int MAXW = SETTLE_CYC + 8;
  logic [3:0] d;
  logic [3:0] r;
  assign d = comm_dip_switch;
  assign r = address_rotary_switch;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_cap;
    $rose(cfgLoaded);
  endsequence
  sequence s_load;
    ##[1:MAXW] cfgLoaded;
  endsequence
  AST_RATE: assert property (s_cap |->
    cfgOut.rate == (d[0] ? FSC_RATE_10M : FSC_RATE_4M)) else $error("rate");
  AST_LEN: assert property (s_cap |->
    cfgOut.frameLen == ((d[0] & d[1]) ? 6'h20 : 6'h11)) else $error("len");
  AST_ADDR: assert property (s_cap |->
    cfgOut.stationAddr == {2'b10, d[2], r}) else $error("address");
  AST_VALID: assert property (s_cap |->
    cfgOut.addrValid == (d[2] | (r != 4'h0))) else $error("valid");
  AST_ERR: assert property (cfgLoaded |->
    cfgOut.cfgError == !cfgOut.addrValid) else $error("cfg error");
  AST_HOLD: assert property (cfgLoaded && $past(cfgLoaded) |->
    $stable(cfgOut)) else $error("config moved");
  AST_STAY: assert property (cfgLoaded |=> cfgLoaded)
    else $error("loaded dropped");
  AST_LOAD: assert property ($rose(reset_n) |-> s_load)
    else $error("no load");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no answer");
endmodule : fsc_decoder_chk
bind fsc_decoder fsc_decoder_chk #(.SETTLE_CYC(SETTLE_CYC)) i_fsc_decoder_chk (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .comm_dip_switch(comm_dip_switch),
  .address_rotary_switch(address_rotary_switch),
  .cfgOut(cfgOut),
  .cfgLoaded(cfgLoaded),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o)
);

/* File: tb/tb_top.sv */
// self-checking bench for the switch configuration decoder
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  logic clk_sys = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, dato;
  logic [7:0] setting = 8'h31;
  logic [3:0] dip, rot, sel = 4'hf;
  logic ack, err, irq, loaded, e, v;
  fsc_cfg_s cfg;
  int n_mismatch = 0, tests_run = 0;
  logic [7:0] tbl [6] = '{8'h31, 8'h00, 8'h2F, 8'h5F, 8'hE0, 8'h7A};
  always #5 clk_sys = ~clk_sys;
  fsc_switch_panel i_fsc_switch_panel (.clk_sys(clk_sys), .setting(setting),
    .dipPins(dip), .rotPins(rot));
  fsc_decoder #(.SETTLE_CYC(16'h0002)) i_fsc_decoder (.clk_sys(clk_sys),
    .reset_n(reset_n), .comm_dip_switch(dip), .address_rotary_switch(rot),
    .cfgOut(cfg), .cfgLoaded(loaded), .irq(irq), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err));
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic bus(logic w, logic [31:0] a, logic [31:0] dw);
    int i;
    @(posedge clk_sys);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= dw;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      summarize();
    end
    rdat = dato;
    e = err;
    cyc <= 0;
    stb <= 0;
  endtask : bus
  // reset value moves with the switches, so compute it per setting
  function automatic logic [31:0] stat_exp(logic [7:0] s);
    logic ok;
    ok = s[6] | (s[3:0] != 4'h0);
    return {10'h000, 1'b1, !ok, ok, 2'b10, s[6], s[3:0], 2'b00,
      ((s[4] & s[5]) ? 6'h20 : 6'h11), 3'b000, s[4]};
  endfunction : stat_exp
  initial begin
    foreach (tbl[k]) begin
      @(posedge clk_sys);
      reset_n <= 0;
      setting <= tbl[k];
      repeat (4) @(posedge clk_sys);
      reset_n <= 1;
      for (int i = 0; i < 50 && loaded !== 1'b1; i++) @(posedge clk_sys);
      if (loaded !== 1'b1) begin
        n_mismatch++;
        summarize();
      end
      v = tbl[k][6] | (tbl[k][3:0] != 4'h0);
      bus(0, 32'h0000_0004, 0);
      check("stat", stat_exp(tbl[k]), rdat);
      setting <= ~tbl[k];
      repeat (6) @(posedge clk_sys);
      bus(0, 32'h0000_0004, 0);
      check("held stat", stat_exp(tbl[k]), rdat);
      bus(0, 32'h0000_0010, 0);
      check("raw pins", {24'h0, ~tbl[k]}, rdat);
      bus(0, 32'h0000_0008, 0);
      check("irq stat", {29'h0, 1'b1, !v, 1'b1}, rdat);
      check("irq masked", 32'h0, {31'h0, irq});
      bus(0, 32'h0000_0000, 0);
      check("ctrl", 32'h0, rdat);
      bus(1, 32'h0000_000C, 32'h0000_0007);
      bus(0, 32'h0000_000C, 0);
      check("irq mask", 32'h7, rdat);
      repeat (2) @(posedge clk_sys);
      check("irq raised", 32'h1, {31'h0, irq});
      sel <= 4'h0;
      bus(1, 32'h0000_0008, 32'h0000_0007);
      sel <= 4'hf;
      check("sel refused", 32'h1, {31'h0, irq});
      bus(1, 32'h0000_0008, 32'h0000_0007);
      repeat (2) @(posedge clk_sys);
      check("irq cleared", 32'h0, {31'h0, irq});
      bus(0, 32'h0000_0020, 0);
      check("unmapped err", 32'h1, {31'h0, e});
      $display("test %0d done", k);
    end
    summarize();
  end
endmodule : tb_top
